/* sbam_chk.sv */
/*
  Port checker for the address mapper.
  Assumes the mode strap is steady while out of reset.
*/
`timescale 1ns/100ps
module sbam_chk
  import sbam_pkg::*;
#(
  parameter int GFX_MB = 4
)
(
  input wire logic                    i_clk, i_rst, i_req, i_gfx,
  input wire sbam_mode_t              i_mode,
  input wire logic [SBAM_HADDR_W-1:0] i_addr,
  input wire logic [SBAM_DATA_W-1:0]  i_wdata, o_wdata,
  input wire logic                    o_err, o_busy, o_ba0,
  input wire logic [1:0]              o_cmd, o_chip_select_n,
  input wire logic [10:0]             o_mem_addr_pins,
  input wire logic                    o_chip_select_two_n,
  input wire logic                    o_chip_select_three_n
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  wire logic take = i_req && !o_busy;
  wire logic rw = o_cmd[1];
  wire logic m16 = i_mode == SBAM_MODE_16M_2B;
  chk_take_act: assert property (take |=> o_err or ##1 o_cmd == 2'h1)
    else $error("accepted request gave no activate");
  chk_rw_after: assert property (o_cmd == 2'h1 |=> rw)
    else $error("activate not followed by read or write");
  chk_ba_again: assert property (o_cmd == 2'h1 |=> $stable(o_ba0))
    else $error("bank select changed between phases");
  chk_err_quiet: assert property (o_err |-> (o_cmd == 2'h0)[*2])
    else $error("refused request produced a command");
  chk_gfx_range: assert property (take && i_gfx &&
    i_addr >= (GFX_MB << 20) |=> o_err)
    else $error("graphics address past region not refused");
  chk_wr_word: assert property (o_cmd == 2'h3 |->
    o_wdata == $past(i_wdata, 3))
    else $error("write word differs from request");
  chk_one_select: assert property (o_cmd == 2'h1 |-> (m16 ?
    $onehot(~{o_chip_select_three_n, o_chip_select_two_n,
    o_chip_select_n}) : $onehot(~o_chip_select_n)))
    else $error("not exactly one bank selected");
  chk_col_zero: assert property (rw |-> !o_mem_addr_pins[10])
    else $error("column pin ten not zero");
  chk_col_ma11: assert property (rw && !m16 |-> !o_chip_select_two_n)
    else $error("column pin eleven not zero");
  chk_ba1_again: assert property (o_cmd == 2'h1 && i_mode ==
    SBAM_MODE_64M_4B |=> $stable(o_chip_select_three_n))
    else $error("second bank bit changed between phases");
endmodule : sbam_chk
bind sbam_top sbam_chk #(.GFX_MB(GFX_MB)) sbam_chk_inst (.i_clk, .i_rst,
  .i_req, .i_gfx, .i_mode, .i_addr, .i_wdata, .o_wdata, .o_err, .o_busy,
  .o_ba0, .o_cmd, .o_chip_select_n, .o_mem_addr_pins,
  .o_chip_select_two_n, .o_chip_select_three_n);

/* sbam_map.sv */
/*
  Combinational address slicer: turns a host byte address into row and
  column pin patterns plus bank-select bits for one density mode.
  Assumes the caller registers the results.
*/
`timescale 1ns/100ps
module sbam_map
  import sbam_pkg::*;
(
  // Configuration and address
  input  wire sbam_mode_t                 i_mode,
  input  wire logic [SBAM_HADDR_W-1:0]    i_addr,
  // Mapped fields
  output logic       [SBAM_PIN_W-1:0]     o_row,
  output logic       [SBAM_PIN_W-1:0]     o_col,
  output logic                            o_ba0,
  output logic                            o_ba1
);

  wire [7:0] col_lo = i_addr[10:SBAM_COL_LO];

  always_comb
  begin
    o_ba0 = i_addr[SBAM_BA0_BIT];
    o_ba1 = 1'b0;
    o_row = '0;
    o_col = '0;
    unique case (i_mode)
      SBAM_MODE_16M_2B:
      begin
        o_row = {2'b00, i_addr[22:12]};                             // R7
        o_col = {2'b00, 1'b0, i_addr[24:23], col_lo};               // R7
      end
      SBAM_MODE_64M_2B:
      begin
        o_row = i_addr[24:12];                                      // R8
        o_col = {3'b000, i_addr[26:25], col_lo};                    // R8
      end
      SBAM_MODE_64M_4B:
      begin
        o_ba1 = i_addr[SBAM_BA1_BIT];                               // R9
        o_row = {1'b0, i_addr[24:13]};                              // R9
        o_col = {3'b000, i_addr[26:25], col_lo};                    // R9
      end
      default:
      begin
        o_row = '0;
        o_col = '0;
      end
    endcase
  end

endmodule : sbam_map

/* sbam_pkg.sv */
/*
  Constants for the SDRAM bank address mapper: density modes, commands,
  address field positions and capacity limits.
  Assumes a single memory clock domain; nothing here is timed.
*/
package sbam_pkg;

  typedef enum logic [1:0] {
    SBAM_MODE_16M_2B,
    SBAM_MODE_64M_2B,
    SBAM_MODE_64M_4B
  } sbam_mode_t;

  typedef enum logic [1:0] {
    SBAM_CMD_NOP,
    SBAM_CMD_ACT,
    SBAM_CMD_RD,
    SBAM_CMD_WR
  } sbam_cmd_t;

  localparam int SBAM_HADDR_W    = 27;
  localparam int SBAM_PIN_W      = 13;
  localparam int SBAM_DATA_W     = 64;
  localparam int SBAM_CS_BANKS   = 4;
  localparam int SBAM_MAX_MB     = 128;
  localparam int SBAM_BA0_BIT    = 11;
  localparam int SBAM_BA1_BIT    = 12;
  localparam int SBAM_ROW_LO_2B  = 12;
  localparam int SBAM_ROW_LO_4B  = 13;
  localparam int SBAM_COL_LO     = 3;
  localparam int SBAM_BANK_SEL_LO = 25;
  localparam logic [SBAM_HADDR_W-1:0] SBAM_GFX_BASE = 27'h0000000;

endpackage : sbam_pkg

/* sbam_sdram_model.sv */
/*
  Memory-side model: latches what the pins show on activate and on
  read or write. Assumes pins change only after rising edges.
*/
`timescale 1ns/100ps
module sbam_sdram_model
  import sbam_pkg::*;
(
  input  wire logic                   i_clk, i_rst, i_ba0,
  input  wire logic [1:0]             i_cmd, i_cs_n,
  input  wire logic [12:0]            i_pins,
  input  wire logic [SBAM_DATA_W-1:0] i_wdata,
  output logic      [14:0]            o_act,
  output logic      [12:0]            o_col,
  output logic      [1:0]             o_ba,
  output logic      [SBAM_DATA_W-1:0] o_word,
  output logic      [7:0]             o_cnt
);
  always_ff @(posedge i_clk or posedge i_rst)
    if (i_rst)
      {o_act, o_col, o_ba, o_word, o_cnt} <= '0;
    else if (i_cmd == SBAM_CMD_ACT)
    begin
      o_act <= {i_cs_n, i_pins};
      o_ba[1] <= i_ba0;
    end
    else if (i_cmd[1])
    begin
      o_col <= i_pins;
      o_ba[0] <= i_ba0;
      o_cnt <= o_cnt + 8'h01;
      if (i_cmd == SBAM_CMD_WR)
        o_word <= i_wdata;
    end
endmodule : sbam_sdram_model

/* sbam_top.sv */
/*
  SDRAM bank address mapper. Takes host access requests with a byte
  address and drives bank-select, memory address and chip-select pins
  for activate and read/write commands, per the density mode.
  Assumes the command sequencer outside sets timing between commands and
  that the density mode is strapped before the first request.
*/
// Notes on behaviour
// R1 - Addresses at or above 128 MB are refused and never reach the pins.
// R2 - Every bank is 64 bits wide and takes whole 64-bit words.
// R3 - With 16 Mbit parts up to four banks, each with its own chip select.
// R4 - 64/128 Mbit parts allow two banks; selects 2 and 3 become address.
// R5 - Select two is row bit 11, select three row bit 12 or bank bit one.
// R6 - Graphics sits at the bottom of bank zero with host memory above.
// R7 - 16 Mbit two-bank mapping of bank, row and column.
// R8 - 64/128 Mbit two-bank mapping of bank, row and column.
// R9 - 64/128 Mbit four-bank mapping of bank, row and column.
// R10 - A density mode, captured at reset release, fixes the mapping.
// R11 - Bank bits go with the row on activate and again with the column.
`timescale 1ns/100ps
module sbam_top
  import sbam_pkg::*;
#(
  parameter int GFX_MB = 4
)
(
  // Clock and reset
  input  wire logic                       i_clk,
  input  wire logic                       i_rst,
  // Configuration strap
  input  wire sbam_mode_t                 i_mode,
  // Request port
  input  wire logic                       i_req,
  input  wire logic                       i_gfx,
  input  wire logic                       i_wr,
  input  wire logic [SBAM_HADDR_W-1:0]    i_addr,
  input  wire logic [SBAM_DATA_W-1:0]     i_wdata,
  // Request status
  output logic                            o_err,
  output logic                            o_busy,
  // SDRAM pins
  output logic [1:0]                      o_cmd,
  output logic [10:0]                     o_mem_addr_pins,
  output logic                            o_ba0,
  output logic [1:0]                      o_chip_select_n,
  output logic                            o_chip_select_two_n,
  output logic                            o_chip_select_three_n,
  output logic [SBAM_DATA_W-1:0]          o_wdata
);

  typedef enum logic [1:0] {SBAM_ST_IDLE, SBAM_ST_ACT, SBAM_ST_COL}
    sbam_state_t;

  localparam logic [SBAM_HADDR_W-1:0] SBAM_LIMIT = 27'h7FFFFFF;
  localparam logic [SBAM_HADDR_W-1:0] SBAM_GFX_SIZE =
    SBAM_HADDR_W'(GFX_MB * 1024 * 1024);

  sbam_state_t                 state_r, state_nxt;
  sbam_mode_t                  mode_r;
  logic                        mode_ok_r;
  logic [SBAM_HADDR_W-1:0]     addr_r;
  logic                        wr_r;
  logic [SBAM_DATA_W-1:0]      wdata_r;
  logic [SBAM_PIN_W-1:0]       row_w, col_w;
  logic                        ba0_w, ba1_w;

  // Host addresses are placed above graphics; beyond 128 MB is refused.
  wire [SBAM_HADDR_W:0] host_abs = {1'b0, i_addr} + {1'b0, SBAM_GFX_SIZE};
  wire [SBAM_HADDR_W-1:0] phys_w =
    i_gfx ? (SBAM_GFX_BASE | i_addr) : host_abs[SBAM_HADDR_W-1:0];  // R6
  wire gfx_oob  = i_gfx && (i_addr >= SBAM_GFX_SIZE);
  wire host_oob = !i_gfx && host_abs[SBAM_HADDR_W];                  // R1
  wire addr_bad = gfx_oob || host_oob || (phys_w > SBAM_LIMIT);      // R1
  wire accept   = i_req && (state_r == SBAM_ST_IDLE) && mode_ok_r;
  wire four_cs  = (mode_r == SBAM_MODE_16M_2B);                      // R3

  // Bank index from the top address bits; two-bank modes use only one bit.
  wire [1:0] bank_w = four_cs ? addr_r[24:23] : {1'b0, addr_r[25]};  // R4

  sbam_map sbam_map_inst (
    .i_mode (mode_r),
    .i_addr (addr_r),
    .o_row  (row_w),
    .o_col  (col_w),
    .o_ba0  (ba0_w),
    .o_ba1  (ba1_w)
  );

  wire act_ph  = (state_r == SBAM_ST_ACT);
  wire col_ph  = (state_r == SBAM_ST_COL);
  wire drive   = act_ph || col_ph;
  wire [SBAM_PIN_W-1:0] pins_w = act_ph ? row_w : col_w;            // R11
  // In wide modes selects two and three carry address or bank bits.
  wire cs2_w = four_cs ? !(drive && bank_w == 2'd2) : pins_w[11];    // R5
  wire cs3_w = four_cs ? !(drive && bank_w == 2'd3) :
               (mode_r == SBAM_MODE_64M_4B) ? ba1_w : pins_w[12];    // R5
  wire [1:0] cs_lo_w = {!(drive && bank_w == 2'd1),
                        !(drive && bank_w == 2'd0)};                 // R3

  // Next values of the output flops. Address pins and o_ba0 park at zero
  // between commands so that a pin left floating in a trace is not read
  // as part of the next access.
  wire                   load_w    = accept && !addr_bad;
  wire                   err_nxt   = accept && addr_bad;             // R1
  wire                   busy_nxt  = !mode_ok_r ||
                                     (state_nxt != SBAM_ST_IDLE);
  wire [1:0]             cmd_nxt   = act_ph ? SBAM_CMD_ACT :
                                     col_ph ? (wr_r ? SBAM_CMD_WR :
                                     SBAM_CMD_RD) : SBAM_CMD_NOP;    // R11
  wire [10:0]            pins_nxt  = drive ? pins_w[10:0] : 11'h000;
  wire                   ba0_nxt   = drive && ba0_w;                 // R5
  wire [SBAM_DATA_W-1:0] wdata_nxt = col_ph ? wdata_r : '0;          // R2

  always_comb
  begin
    state_nxt = state_r;
    unique case (state_r)
      SBAM_ST_IDLE:
        if (load_w)
          state_nxt = SBAM_ST_ACT;
      SBAM_ST_ACT:
        state_nxt = SBAM_ST_COL;                                     // R11
      SBAM_ST_COL:
        state_nxt = SBAM_ST_IDLE;
    endcase
  end

  // Mode is a strap: caught on the first clock after reset is released.
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      mode_r    <= SBAM_MODE_16M_2B;
      mode_ok_r <= 1'b0;
    end
    else if (!mode_ok_r)
    begin
      mode_r    <= i_mode;                                           // R10
      mode_ok_r <= 1'b1;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
      state_r <= SBAM_ST_IDLE;
    else
      state_r <= state_nxt;                                          // R11
  end

  // The request is copied once, so both phases show the same address even
  // when the host moves its inputs while the access is still running.
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      addr_r  <= '0;
      wr_r    <= 1'b0;
      wdata_r <= '0;
    end
    else if (load_w)
    begin
      addr_r  <= phys_w;
      wr_r    <= i_wr;
      wdata_r <= i_wdata;                                            // R2
    end
  end

  // Busy comes up in reset, so nothing is taken before the strap is read.
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_err  <= 1'b0;
      o_busy <= 1'b1;
    end
    else
    begin
      o_err  <= err_nxt;                                             // R1
      o_busy <= busy_nxt;                                            // R10
    end
  end

  // Command, address and bank pins leave from one flop stage, so the
  // memory sees them change together on the same edge.
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_cmd           <= SBAM_CMD_NOP;
      o_mem_addr_pins <= '0;
      o_ba0           <= 1'b0;
    end
    else
    begin
      o_cmd           <= cmd_nxt;                                    // R11
      o_mem_addr_pins <= pins_nxt;                                   // R11
      o_ba0           <= ba0_nxt;                                    // R5
    end
  end

  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_chip_select_n       <= 2'b11;
      o_chip_select_two_n   <= 1'b1;
      o_chip_select_three_n <= 1'b1;
    end
    else
    begin
      o_chip_select_n       <= cs_lo_w;                              // R3
      o_chip_select_two_n   <= cs2_w;                                // R5
      o_chip_select_three_n <= cs3_w;                                // R5
    end
  end

  // The word is shown in the column phase of reads and writes alike; zero
  // elsewhere keeps the data pins quiet between accesses.
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
      o_wdata <= '0;
    else
      o_wdata <= wdata_nxt;                                          // R2
  end

endmodule : sbam_top

/* test_sbam_top.sv */
/*
  Self-checking bench for the mapper, one reset per density mode and one more for the range checks.
  Assumes the memory model sits on the pins.
*/
`timescale 1ns/100ps
module test_sbam_top;
  import sbam_pkg::*;
  localparam int GFX = 4;
  logic i_clk = 1'b0, i_rst = 1'b1, i_req = 1'b0, i_gfx = 1'b0, i_wr = 1'b0;
  sbam_mode_t i_mode = SBAM_MODE_16M_2B;
  logic [SBAM_HADDR_W-1:0] i_addr = '0;
  logic [SBAM_DATA_W-1:0] i_wdata = '0, o_wdata, word;
  logic [1:0] o_cmd, o_chip_select_n, ba;
  logic [10:0] o_mem_addr_pins;
  logic o_err, o_busy, o_ba0, o_chip_select_two_n, o_chip_select_three_n, seen;
  logic [14:0] act;
  logic [12:0] col;
  logic [7:0] cnt;
  int error_cnt = 0, comparisons = 0;
  initial forever #2.5 i_clk = ~i_clk;
  sbam_top #(.GFX_MB(GFX)) sbam_top_inst (.i_clk, .i_rst, .i_mode, .i_req,
    .i_gfx, .i_wr, .i_addr, .i_wdata, .o_err, .o_busy, .o_cmd, .o_ba0,
    .o_mem_addr_pins, .o_chip_select_n, .o_chip_select_two_n,
    .o_chip_select_three_n, .o_wdata);
  sbam_sdram_model sbam_sdram_model_inst (.i_clk, .i_rst, .i_ba0(o_ba0),
    .i_cmd(o_cmd), .i_cs_n(o_chip_select_n), .i_wdata(o_wdata), .o_act(act),
    .i_pins({o_chip_select_three_n, o_chip_select_two_n, o_mem_addr_pins}),
    .o_col(col), .o_ba(ba), .o_word(word), .o_cnt(cnt));
  task automatic cmp(input logic [63:0] got, exp);
    comparisons++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : cmp
  task automatic rst(input sbam_mode_t m);
    i_rst = 1'b1;
    i_mode = m;
    repeat (12) @(negedge i_clk);
    cmp({o_busy, o_cmd, o_chip_select_n}, 5'h13);
    i_rst = 1'b0;
    repeat (2) @(negedge i_clk);
    cmp(o_busy, 1'b0);
  endtask : rst
  task automatic go(input logic g, w, input logic [26:0] a,
                    input logic [63:0] d);
    for (int k = 0; k < 20 && o_busy !== 1'b0; k++) @(negedge i_clk);
    cmp(o_busy, 1'b0);
    {i_req, i_gfx, i_wr, i_addr, i_wdata} = {1'b1, g, w, a, d};
    @(negedge i_clk);
    i_req = 1'b0;
    seen = o_err;
    repeat (4) @(negedge i_clk) seen |= o_err;
  endtask : go
  task automatic one(input logic g, w, input logic [26:0] p,
                     input logic [63:0] d);
    logic [3:0] s;
    logic [12:0] ec;
    logic [14:0] ea;
    logic [7:0] c0;
    c0 = cnt;
    s = ~(4'h1 << p[24:23]);
    ec = {p[12], 2'h0, p[26:25], p[10:3]};
    ea = {~(2'h1 << p[25]), p[12], p[24:13]};
    if (i_mode == SBAM_MODE_16M_2B)
      {ec, ea} = {3'h0, p[24:23], p[10:3], s[1:0], s[3:2], p[22:12]};
    else if (i_mode == SBAM_MODE_64M_2B)
      {ec, ea} = {3'h0, p[26:25], p[10:3], ~(2'h1 << p[25]), p[24:12]};
    go(g, w, g ? p : 27'(p - (GFX << 20)), d);
    cmp(act, ea);
    cmp(col & (i_mode == SBAM_MODE_16M_2B ? 13'h07FF : 13'h1FFF), ec);
    cmp(ba, {2{p[11]}});
    cmp({seen, cnt}, {1'b0, 8'(c0 + 8'h01)});
    if (w) cmp(word, d);
  endtask : one
  task automatic t_16m;
    rst(SBAM_MODE_16M_2B);
    for (int b = 0; b < 4; b++) one(1'b0, b[0], {2'h0, b[1:0], 23'h6A5AB8}, {16{b[3:0]}});
    one(1'b1, 1'b1, 27'h03FFFF8, 64'hA5A5_0F0F_1234_5678);
  endtask : t_16m
  task automatic t_64m(input sbam_mode_t m);
    rst(m);
    one(1'b0, 1'b1, 27'h7FFFFF8, 64'hFEDC_BA98_7654_3210);
    one(1'b0, 1'b0, 27'h15A4A58, 64'h0);
  endtask : t_64m
  task automatic t_range;
    rst(SBAM_MODE_16M_2B);
    go(1'b0, 1'b1, 27'h7C00000, 64'h1);
    cmp({seen, cnt}, 9'h100);
    go(1'b1, 1'b0, 27'h0400000, 64'h2);
    cmp({seen, cnt}, 9'h100);
  endtask : t_range
  task automatic complete_run;
    $display("comparisons %0d error_cnt %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : complete_run
  initial
  begin
    #20000;
    error_cnt++;
    complete_run;
  end
  initial
  begin
    t_16m;
    t_64m(SBAM_MODE_64M_2B);
    t_64m(SBAM_MODE_64M_4B);
    t_range;
    complete_run;
  end
endmodule : test_sbam_top
